// [src/hbs_consts.svh]
`ifndef HBS_CONSTS_SVH
`define HBS_CONSTS_SVH

// ****************************************
// Register offsets seen over the link
// ****************************************
`define HBS_REG_DONE 8'hff
`define HBS_REG_CTRL 8'h01
`define HBS_REG_SOCVAL 8'h02
`define HBS_REG_SOCMASK 8'h03

// ****************************************
// Control register fields and reset value
// ****************************************
`define HBS_CTRL_UPCHG 0
`define HBS_CTRL_AWAKE 1
`define HBS_CTRL_CONN 2
`define HBS_CTRL_SOFTDISC 3
`define HBS_CTRL_RST 8'h01
`define HBS_CFG_DEF 8'h00

// ****************************************
// Synchronised pin indexes
// ****************************************
`define HBS_PIN_REF 0
`define HBS_PIN_PLL 1
`define HBS_PIN_VBUS 2
`define HBS_PIN_SDA 3
`define HBS_PIN_SCL 4
`define HBS_PIN_CHG 5
`define HBS_PIN_SUSP 6
`define HBS_PIN_ROM 7
`define HBS_NPIN 8

// ****************************************
// Timing
// ****************************************
`define HBS_CLK_MHZ 250
`define HBS_REG12_NS 10000
`define HBS_PROBE_NS 1000
`define HBS_MERGE_CYC 4

`endif

// [src/hbs_link_port.sv]
`timescale 1ns/1ps
`default_nettype none
module hbs_link_port (
    // Link clock and reset
    input wire logic i_lk_clk,
    input wire logic i_arst_n,
    // Link write strobe
    input wire logic i_lk_wr,
    input wire logic [7:0] i_lk_addr,
    input wire logic [7:0] i_lk_data,
    output logic o_lk_ack,
    output logic o_lk_nak,
    // Core side
    hbs_xfer_if.link xf
);
    import hbs_pkg::*;

    typedef struct packed {
        logic [1:0] en_s;
        logic [1:0] ack_s;
        logic req_tgl;
        logic [7:0] addr;
        logic [7:0] data;
        logic ack;
        logic nak;
    } hbs_link_s;

    hbs_link_s q;
    hbs_link_s n;
    logic pending;

    // ****************************************
    // Next state
    // ****************************************
    // One write in flight; a second one is refused until the core answers
    always_comb begin
        n = q;
        n.en_s = {q.en_s[0], xf.smb_en};
        n.ack_s = {q.ack_s[0], xf.ack_tgl};
        pending = q.req_tgl != q.ack_s[1];
        n.ack = 1'b0;
        n.nak = 1'b0;
        if (i_lk_wr) begin
            if (q.en_s[1] && !pending) begin
                n.req_tgl = ~q.req_tgl;
                n.addr = i_lk_addr;
                n.data = i_lk_data;
                n.ack = 1'b1;
            end else begin
                n.nak = 1'b1;
            end
        end
    end

    // Link state register
    always_ff @(posedge i_lk_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign xf.req_tgl = q.req_tgl;
    assign xf.addr = q.addr;
    assign xf.data = q.data;
    assign o_lk_ack = q.ack;
    assign o_lk_nak = q.nak;
endmodule
`default_nettype wire

// [src/hbs_pkg.sv]
package hbs_pkg;
    // Boot sequencer stages
    typedef enum logic [3:0] {
        ST_STANDBY,
        ST_HARDWARE_INIT_STAGE,
        ST_FW_INIT,
        ST_ROM_LOAD,
        ST_SOC_CFG,
        ST_CONFIG,
        ST_IDLE,
        ST_CHG_DET,
        ST_CONNECT,
        ST_NORMAL
    } hbs_stage_e;
endpackage

// [src/hbs_sequencer.sv]
// How it works
// - Reset pin low: standby, ports undriven, all regulators off.
// - Reset pin high: run the hub boot stages towards normal operation.
// - Nothing survives standby; every setting restarts from defaults.
// - Hardware init enables 1.2V, waits settle, locks PLL only with reference.
// - Hardware init loads register defaults and latches the straps.
// - Link writes are refused during hardware init.
// - Leave hardware init only while a reference clock is present.
// - Straps selecting ROM loading fetch configuration from external ROM.
// - Otherwise probe with weak pull-downs; both lines high means bus present.
// - Bus found: enter SoC configuration stage.
// - SoC configuration stage waits forever for link writes.
// - Merge defaults, SoC data and OTP data, then apply.
// - No VBUS and no connect request: go idle, then suspend.
// - VBUS: charger detect if charging enabled, else connect.
// - Charger detect disabled skips to connect; enabled starts detection.
// - Detection complete moves to upstream connect.
// - Normal mode: only the run-time register is writable.
// - Reset pin low from any stage returns to standby.
// - Soft disconnect holds the connect stage until released.
// - Suspend refuses link writes unless keep-awake was set.
// - 3.3V regulator follows the reset pin.
`timescale 1ns/1ps
`default_nettype none
`include "hbs_consts.svh"
module hbs_sequencer #(
    parameter int REG12_CYC = (`HBS_REG12_NS * `HBS_CLK_MHZ + 999) / 1000,
    parameter int PROBE_CYC = (`HBS_PROBE_NS * `HBS_CLK_MHZ + 999) / 1000,
    parameter logic [7:0] CFG_DEFAULT = `HBS_CFG_DEF
) (
    // Core clock and reset pin
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Link clock and write strobe
    input wire logic i_lk_clk,
    input wire logic i_lk_wr,
    input wire logic [7:0] i_lk_addr,
    input wire logic [7:0] i_lk_data,
    output logic o_lk_ack,
    output logic o_lk_nak,
    // Clock, power and straps
    input wire logic i_reference_clock_in_ok,
    input wire logic i_pll_lock,
    input wire logic [1:0] i_cfg_sel,
    output logic o_reg33_en,
    output logic o_reg12_en,
    output logic o_pll_en,
    // Bus probe pins
    input wire logic i_sda_pin,
    input wire logic i_scl_pin,
    output logic o_probe_pd_en,
    // External ROM load
    output logic o_rom_load,
    input wire logic i_rom_done,
    // OTP data for the merge
    input wire logic [7:0] i_otp_val,
    input wire logic [7:0] i_otp_mask,
    // Upstream and charger
    input wire logic i_vbus,
    input wire logic i_usb_suspend,
    input wire logic i_chg_done,
    output logic o_chg_start,
    output logic o_port_oe,
    output logic o_connect,
    output logic o_suspend,
    // Status
    output var hbs_pkg::hbs_stage_e o_stage,
    output logic [7:0] o_cfg,
    output logic [7:0] o_ctrl
);
    import hbs_pkg::*;

    typedef struct packed {
        hbs_stage_e st;
        logic [1:0] rst_q;
        logic [`HBS_NPIN-1:0] sy1;
        logic [`HBS_NPIN-1:0] sy2;
        logic [2:0] rq;
        logic ack_tgl;
        logic smb_en;
        logic [1:0] cfg_s1;
        logic [1:0] cfg_s2;
        logic [1:0] cfg_sel;
        logic strap_sda;
        logic [7:0] ctrl;
        logic [7:0] soc_val;
        logic [7:0] soc_mask;
        logic [7:0] cfg;
        logic [15:0] cnt;
        logic chg_start;
    } hbs_core_s;

    localparam logic [15:0] REG12_N = 16'(REG12_CYC);
    localparam logic [15:0] PROBE_N = 16'(PROBE_CYC);
    localparam logic [15:0] MERGE_N = 16'(`HBS_MERGE_CYC);

    hbs_core_s q;
    hbs_core_s n;
    hbs_xfer_if xf ();

    logic [`HBS_NPIN-1:0] pin;
    logic new_wr;
    logic chg_en;
    logic susp;

    // ****************************************
    // Helpers
    // ****************************************
    // Which offsets a given stage lets the SoC write
    function automatic logic wr_ok(input hbs_stage_e st, input logic [7:0] a);
        logic ok;
        ok = 1'b0;
        if (st == ST_SOC_CFG) begin
            ok = (a == `HBS_REG_DONE) || (a == `HBS_REG_CTRL) ||
                 (a == `HBS_REG_SOCVAL) || (a == `HBS_REG_SOCMASK);
        end else if (st == ST_CONNECT || st == ST_NORMAL || st == ST_IDLE) begin
            ok = (a == `HBS_REG_CTRL);
        end
        return ok;
    endfunction

    // Pick the next stage once configuration or idle decides
    function automatic hbs_stage_e after_cfg(input logic vbus, input logic conn,
                                             input logic chg);
        hbs_stage_e s;
        s = ST_IDLE;
        if (vbus) begin
            s = chg ? ST_CHG_DET : ST_CONNECT;
        end else if (conn) begin
            s = ST_CONNECT;
        end
        return s;
    endfunction

    // ****************************************
    // Link side
    // ****************************************
    hbs_link_port hbs_link_port_inst (
        .i_lk_clk(i_lk_clk),
        .i_arst_n(i_arst_n),
        .i_lk_wr(i_lk_wr),
        .i_lk_addr(i_lk_addr),
        .i_lk_data(i_lk_data),
        .o_lk_ack(o_lk_ack),
        .o_lk_nak(o_lk_nak),
        .xf(xf.link)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        pin = '0;
        pin[`HBS_PIN_REF] = i_reference_clock_in_ok;
        pin[`HBS_PIN_PLL] = i_pll_lock;
        pin[`HBS_PIN_VBUS] = i_vbus;
        pin[`HBS_PIN_SDA] = i_sda_pin;
        pin[`HBS_PIN_SCL] = i_scl_pin;
        pin[`HBS_PIN_CHG] = i_chg_done;
        pin[`HBS_PIN_SUSP] = i_usb_suspend;
        pin[`HBS_PIN_ROM] = i_rom_done;
        n = q;
        new_wr = 1'b0;
        chg_en = q.ctrl[`HBS_CTRL_UPCHG];
        susp = (q.st == ST_IDLE) || q.sy2[`HBS_PIN_SUSP];
        if (i_ce) begin
            n.rst_q = {q.rst_q[0], 1'b1};
            n.sy1 = pin;
            n.sy2 = q.sy1;
            // Straps are pins too, so they get the same two flops
            n.cfg_s1 = i_cfg_sel;
            n.cfg_s2 = q.cfg_s1;
            // Toggle handshake; first stage only feeds the second
            n.rq = {q.rq[1], q.rq[0], xf.req_tgl};
            new_wr = q.rq[2] != q.rq[1];
            n.ack_tgl = q.rq[1];
            n.chg_start = 1'b0;
            n.cnt = q.cnt + 16'h0001;
            n.smb_en = (q.st == ST_SOC_CFG) ||
                       ((q.st == ST_CONNECT || q.st == ST_NORMAL || q.st == ST_IDLE) &&
                        (!susp || q.ctrl[`HBS_CTRL_AWAKE]));
            // Link writes; a late write after the gate closed is dropped
            // run-time subset
            if (new_wr && q.smb_en && wr_ok(q.st, xf.addr)) begin
                unique case (xf.addr)
                    `HBS_REG_CTRL: n.ctrl = xf.data;
                    `HBS_REG_SOCVAL: n.soc_val = xf.data;
                    `HBS_REG_SOCMASK: n.soc_mask = xf.data;
                    default: ;
                endcase
            end
            unique case (q.st)
                ST_STANDBY: begin
                    if (q.rst_q[1]) begin
                        n.st = ST_HARDWARE_INIT_STAGE;
                        n.cnt = '0;
                        n.ctrl = `HBS_CTRL_RST;
                        n.soc_val = '0;
                        n.soc_mask = '0;
                        n.cfg = CFG_DEFAULT;
                    end
                end
                ST_HARDWARE_INIT_STAGE: begin
                    if (q.cnt >= REG12_N) begin
                        n.cnt = REG12_N;
                        if (q.sy2[`HBS_PIN_REF] && q.sy2[`HBS_PIN_PLL]) begin
                            // latch straps
                            // Strap copy taken from the synchronised pair
                            n.cfg_sel = q.cfg_s2;
                            n.strap_sda = q.sy2[`HBS_PIN_SDA];
                            n.st = ST_FW_INIT;
                            n.cnt = '0;
                        end
                    end
                end
                ST_FW_INIT: begin
                    if (q.cfg_sel == 2'h3 && !q.strap_sda) begin
                        n.st = ST_ROM_LOAD;
                    end else if (q.cnt >= PROBE_N) begin
                        if (q.sy2[`HBS_PIN_SDA] && q.sy2[`HBS_PIN_SCL]) begin
                            n.st = ST_SOC_CFG;
                        end else begin
                            n.st = ST_CONFIG;
                        end
                        n.cnt = '0;
                    end
                end
                ST_ROM_LOAD: begin
                    if (q.sy2[`HBS_PIN_ROM]) begin
                        n.st = ST_CONFIG;
                        n.cnt = '0;
                    end
                end
                ST_SOC_CFG: begin
                    n.cnt = '0;
                    if (new_wr && q.smb_en && xf.addr == `HBS_REG_DONE) begin
                        n.st = ST_CONFIG;
                    end
                end
                ST_CONFIG: begin
                    if (q.cnt >= MERGE_N) begin
                        n.cfg = (((CFG_DEFAULT & ~q.soc_mask) | (q.soc_val & q.soc_mask))
                                 & ~i_otp_mask) | (i_otp_val & i_otp_mask);
                        n.st = after_cfg(q.sy2[`HBS_PIN_VBUS],
                                         q.ctrl[`HBS_CTRL_CONN], chg_en);
                        n.chg_start = n.st == ST_CHG_DET;
                    end
                end
                ST_IDLE: begin
                    // leave on VBUS or connect request
                    n.st = after_cfg(q.sy2[`HBS_PIN_VBUS],
                                     q.ctrl[`HBS_CTRL_CONN], chg_en);
                    n.chg_start = n.st == ST_CHG_DET;
                end
                ST_CHG_DET: begin
                    if (!chg_en || q.sy2[`HBS_PIN_CHG]) begin
                        n.st = ST_CONNECT;
                    end
                end
                ST_CONNECT: begin
                    if (!q.ctrl[`HBS_CTRL_SOFTDISC]) begin
                        n.st = ST_NORMAL;
                    end
                end
                ST_NORMAL: begin
                    if (q.ctrl[`HBS_CTRL_SOFTDISC]) begin
                        n.st = ST_CONNECT;
                    end
                end
                default: n.st = ST_STANDBY;
            endcase
            // Gate stays shut in standby whatever the stage logic chose
            if (q.st == ST_STANDBY) begin
                n.smb_en = 1'b0;
            end
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // pin low to standby
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign xf.ack_tgl = q.ack_tgl;
    assign xf.smb_en = q.smb_en;
    assign o_reg33_en = i_arst_n;
    assign o_reg12_en = q.st != ST_STANDBY;
    assign o_pll_en = o_reg12_en && q.sy2[`HBS_PIN_REF];
    // Pull-downs only while probing, never on the ROM path
    assign o_probe_pd_en = q.st == ST_FW_INIT && !(q.cfg_sel == 2'h3 && !q.strap_sda);
    assign o_rom_load = q.st == ST_ROM_LOAD;
    assign o_chg_start = q.chg_start;
    assign o_port_oe = q.st == ST_CONNECT || q.st == ST_NORMAL;
    assign o_connect = q.st == ST_NORMAL;
    assign o_suspend = q.st == ST_IDLE;
    assign o_stage = q.st;
    assign o_cfg = q.cfg;
    assign o_ctrl = q.ctrl;
endmodule
`default_nettype wire

// [src/hbs_xfer_if.sv]
`timescale 1ns/1ps
`default_nettype none
// Write transfer from the link domain to the core domain
interface hbs_xfer_if;
    logic req_tgl;
    logic [7:0] addr;
    logic [7:0] data;
    logic ack_tgl;
    logic smb_en;
    modport link (output req_tgl, output addr, output data, input ack_tgl, input smb_en);
    modport core (input req_tgl, input addr, input data, output ack_tgl, output smb_en);
endinterface
`default_nettype wire

// [tb/hbs_seq_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module hbs_seq_chk
    import hbs_pkg::*;
(
    // Core clock and reset pin
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Watched inputs
    input wire logic i_reference_clock_in_ok,
    input wire logic [7:0] i_otp_val,
    input wire logic [7:0] i_otp_mask,
    // Watched outputs
    input wire logic o_lk_ack,
    input wire logic o_reg33_en,
    input wire logic o_reg12_en,
    input wire logic o_pll_en,
    input wire logic o_probe_pd_en,
    input wire logic o_rom_load,
    input wire logic o_chg_start,
    input wire logic o_suspend,
    input wire hbs_pkg::hbs_stage_e o_stage,
    input wire logic [7:0] o_cfg,
    input wire logic [7:0] o_ctrl
);
    // ********
    // Stage checks
    // ********
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    // Boot and config steps
    sequence s_boot;
        o_stage == ST_STANDBY ##[2:3] o_stage == ST_HARDWARE_INIT_STAGE;
    endsequence
    sequence s_leave_cfg;
        o_stage == ST_CONFIG ##1 o_stage != ST_CONFIG;
    endsequence
    sequence s_to_chg;
        o_stage == ST_CONFIG ##1 o_stage == ST_CHG_DET;
    endsequence

    property p_boot;
        $rose(i_arst_n) |-> s_boot;
    endproperty
    property p_reg33;
        o_reg33_en;
    endproperty
    property p_reg12;
        o_reg12_en == (o_stage != ST_STANDBY);
    endproperty
    property p_pll;
        o_pll_en |-> o_reg12_en && $past(i_reference_clock_in_ok, 2);
    endproperty
    property p_hw_quiet;
        o_stage == ST_HARDWARE_INIT_STAGE |-> !o_lk_ack;
    endproperty
    property p_noref;
        (o_stage == ST_HARDWARE_INIT_STAGE && !i_reference_clock_in_ok) [*3] |=> o_stage == ST_HARDWARE_INIT_STAGE;
    endproperty
    property p_probe;
        o_probe_pd_en |-> o_stage == ST_FW_INIT;
    endproperty
    property p_rom;
        o_stage == ST_ROM_LOAD [*2] |-> o_rom_load;
    endproperty
    property p_merge;
        s_leave_cfg |-> (o_cfg & i_otp_mask) == (i_otp_val & i_otp_mask);
    endproperty
    property p_chg;
        s_to_chg |-> o_ctrl[0];
    endproperty
    property p_chg_pulse;
        o_chg_start |-> o_stage == ST_CHG_DET ##1 !o_chg_start;
    endproperty
    property p_idle;
        o_stage == ST_IDLE [*2] |-> o_suspend;
    endproperty
    property p_run_cfg;
        o_stage == ST_NORMAL |=> $stable(o_cfg);
    endproperty
    property p_softdisc;
        o_stage == ST_NORMAL && o_ctrl[3] |-> ##[1:4] o_stage == ST_CONNECT;
    endproperty

    a_boot: assert property (p_boot)
        else $error("late leaving standby");
    a_reg33: assert property (p_reg33)
        else $error("3v3 regulator off");
    a_reg12: assert property (p_reg12)
        else $error("1v2 regulator wrong");
    a_pll: assert property (p_pll)
        else $error("pll on without reference");
    a_hw_quiet: assert property (p_hw_quiet)
        else $error("write taken in hardware init");
    a_noref: assert property (p_noref)
        else $error("left hardware init without reference");
    a_probe: assert property (p_probe)
        else $error("pull-downs outside firmware init");
    a_rom: assert property (p_rom)
        else $error("rom load not requested");
    a_merge: assert property (p_merge)
        else $error("otp bits not merged");
    a_chg: assert property (p_chg)
        else $error("charger stage while disabled");
    a_chg_pulse: assert property (p_chg_pulse)
        else $error("charger start pulse wrong");
    a_idle: assert property (p_idle)
        else $error("idle without suspend");
    a_run_cfg: assert property (p_run_cfg)
        else $error("config changed in normal mode");
    a_softdisc: assert property (p_softdisc)
        else $error("soft disconnect ignored");
endmodule

bind hbs_sequencer hbs_seq_chk hbs_seq_chk_inst (
    .i_clk, .i_arst_n, .i_reference_clock_in_ok, .i_otp_val, .i_otp_mask, .o_lk_ack,
    .o_reg33_en, .o_reg12_en, .o_pll_en, .o_probe_pd_en, .o_rom_load,
    .o_chg_start, .o_suspend, .o_stage, .o_cfg, .o_ctrl
);
`default_nettype wire

// [tb/hbs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module hbs_sequencer_tb;
    import hbs_pkg::*;
    // ********
    // Pins and counters
    // ********
    logic i_clk = 1'b0;
    logic i_arst_n, i_ce, i_lk_clk, i_lk_wr, o_lk_ack, o_lk_nak, i_reference_clock_in_ok, i_pll_lock;
    logic [7:0] i_lk_addr, i_lk_data, i_otp_val, i_otp_mask, o_cfg, o_ctrl;
    logic i_sda_pin, i_scl_pin, i_rom_done, i_vbus, i_usb_suspend, i_chg_done;
    logic o_reg33_en, o_reg12_en, o_pll_en, o_probe_pd_en, o_rom_load, o_chg_start;
    logic o_port_oe, o_connect, o_suspend;
    logic pd_seen = 1'b0;
    logic [1:0] i_cfg_sel, ans;
    hbs_stage_e o_stage;
    int n_fail = 0;
    int tests_run = 0;
    localparam logic [1:0] ACK = 2'b10;
    localparam logic [1:0] NAK = 2'b01;

    // Core clock, 4 ns
    always #2 i_clk = ~i_clk;

    // Short settle and probe counts keep the run brief
    hbs_sequencer #(.REG12_CYC(8), .PROBE_CYC(4)) hbs_sequencer_inst (
        .i_clk, .i_arst_n, .i_ce, .i_lk_clk, .i_lk_wr, .i_lk_addr, .i_lk_data,
        .o_lk_ack, .o_lk_nak, .i_reference_clock_in_ok, .i_pll_lock, .i_cfg_sel, .o_reg33_en,
        .o_reg12_en, .o_pll_en, .i_sda_pin, .i_scl_pin, .o_probe_pd_en, .o_rom_load,
        .i_rom_done, .i_otp_val, .i_otp_mask, .i_vbus, .i_usb_suspend, .i_chg_done,
        .o_chg_start, .o_port_oe, .o_connect, .o_suspend, .o_stage, .o_cfg, .o_ctrl
    );
    hbs_soc_model hbs_soc_model_inst (
        .o_lk_clk(i_lk_clk), .o_lk_wr(i_lk_wr), .o_lk_addr(i_lk_addr),
        .o_lk_data(i_lk_data), .i_lk_ack(o_lk_ack), .i_lk_nak(o_lk_nak)
    );

    // ********
    // Tasks
    // ********
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic lw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp);
        hbs_soc_model_inst.wr(a, d, 3, 12, ans);
        chk({6'h00, ans}, {6'h00, exp});
    endtask
    // Bounded wait at the falling edge, noting any probe pull-down
    task automatic wait_st(input hbs_stage_e s);
        int k;
        k = 0;
        @(negedge i_clk);
        while (o_stage !== s && k < 3000) begin
            pd_seen |= o_probe_pd_en;
            @(negedge i_clk);
            k++;
        end
        chk({4'h0, o_stage}, {4'h0, s});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial begin
        #300000;
        n_fail++;
        wrap_up();
    end

    // ********
    // Test sequence
    // ********
    initial begin
        i_arst_n = 1'b0;
        i_ce = 1'b1;
        i_reference_clock_in_ok = 1'b0;
        i_pll_lock = 1'b0;
        i_cfg_sel = 2'h0;
        i_sda_pin = 1'b1;
        i_scl_pin = 1'b1;
        i_rom_done = 1'b0;
        i_otp_val = 8'h03;
        i_otp_mask = 8'h0f;
        i_vbus = 1'b1;
        i_usb_suspend = 1'b0;
        i_chg_done = 1'b0;
        cyc(2);
        @(negedge i_clk);
        chk({1'b0, o_reg33_en, o_reg12_en, o_port_oe, o_stage}, {4'h0, ST_STANDBY});
        cyc(1);
        i_arst_n <= 1'b1;
        cyc(40);
        wait_st(ST_HARDWARE_INIT_STAGE);
        chk({5'h00, o_reg33_en, o_reg12_en, o_pll_en}, 8'h06);
        chk(o_ctrl, 8'h01);
        lw(8'h01, 8'h00, NAK);
        cyc(1);
        i_reference_clock_in_ok <= 1'b1;
        i_pll_lock <= 1'b1;
        wait_st(ST_SOC_CFG);
        chk({7'h00, pd_seen}, 8'h01);
        $display("test hardware init done");
        cyc(200);
        wait_st(ST_SOC_CFG);
        lw(8'h01, 8'h01, ACK);
        lw(8'h02, 8'ha5, ACK);
        hbs_soc_model_inst.wr(8'h03, 8'hf0, 3, 0, ans);
        chk({6'h00, ans}, {6'h00, ACK});
        // One idle tick between frames; the handshake is still in flight
        hbs_soc_model_inst.wr(8'h02, 8'h00, 1, 12, ans);
        chk({6'h00, ans}, {6'h00, NAK});
        lw(8'hff, 8'h00, ACK);
        wait_st(ST_CHG_DET);
        chk(o_cfg, 8'ha3);
        cyc(1);
        i_chg_done <= 1'b1;
        wait_st(ST_NORMAL);
        chk({6'h00, o_port_oe, o_connect}, 8'h03);
        $display("test soc configuration done");
        lw(8'h02, 8'h5a, ACK);
        cyc(10);
        chk(o_cfg, 8'ha3);
        lw(8'h01, 8'h09, ACK);
        cyc(20);
        wait_st(ST_CONNECT);
        lw(8'h01, 8'h01, ACK);
        wait_st(ST_NORMAL);
        $display("test normal mode done");
        cyc(1);
        i_usb_suspend <= 1'b1;
        cyc(10);
        lw(8'h01, 8'h03, NAK);
        cyc(1);
        i_usb_suspend <= 1'b0;
        cyc(10);
        lw(8'h01, 8'h03, ACK);
        cyc(1);
        i_usb_suspend <= 1'b1;
        cyc(10);
        lw(8'h01, 8'h01, ACK);
        chk(o_ctrl, 8'h01);
        $display("test suspend done");
        cyc(1);
        i_arst_n <= 1'b0;
        i_cfg_sel <= 2'h3;
        i_sda_pin <= 1'b0;
        i_scl_pin <= 1'b0;
        i_vbus <= 1'b0;
        i_usb_suspend <= 1'b0;
        cyc(2);
        @(negedge i_clk);
        chk({1'b0, o_reg33_en, o_reg12_en, o_port_oe, o_stage}, {4'h0, ST_STANDBY});
        cyc(1);
        i_arst_n <= 1'b1;
        wait_st(ST_HARDWARE_INIT_STAGE);
        chk(o_cfg, 8'h00);
        wait_st(ST_ROM_LOAD);
        chk({7'h00, o_rom_load}, 8'h01);
        cyc(1);
        i_rom_done <= 1'b1;
        wait_st(ST_IDLE);
        chk({6'h00, o_suspend, o_port_oe}, 8'h02);
        chk(o_cfg, 8'h03);
        chk(o_ctrl, 8'h01);
        // Clock enable low freezes idle even with VBUS arriving
        cyc(1);
        i_ce <= 1'b0;
        i_vbus <= 1'b1;
        cyc(10);
        wait_st(ST_IDLE);
        cyc(1);
        i_ce <= 1'b1;
        wait_st(ST_NORMAL);
        $display("test second boot done");
        wrap_up();
    end
endmodule
`default_nettype wire

// [tb/hbs_soc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hbs_soc_model (
    // Link pins toward the hub
    output logic o_lk_clk,
    output logic o_lk_wr,
    output logic [7:0] o_lk_addr,
    output logic [7:0] o_lk_data,
    // Answer from the hub
    input wire logic i_lk_ack,
    input wire logic i_lk_nak
);
    // Clock parked low between frames
    initial begin
        o_lk_clk = 1'b0;
        o_lk_wr = 1'b0;
        o_lk_addr = 8'h5a;
        o_lk_data = 8'ha5;
    end

    // One 30 ns period, answer taken late in the high phase
    task automatic tick(output logic [1:0] ans);
        #8;
        o_lk_clk = 1'b1;
        #14;
        ans = {i_lk_ack, i_lk_nak};
        #1;
        o_lk_clk = 1'b0;
        #7;
    endtask

    // Write frame; a short tail leaves the handshake in flight on purpose
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int pre,
                      input int tail, output logic [1:0] ans);
        logic [1:0] idle;
        repeat (pre) tick(idle);
        o_lk_wr = 1'b1;
        o_lk_addr = a;
        o_lk_data = d;
        tick(ans);
        // Released lines show the inverse, never a stale copy
        o_lk_wr = 1'b0;
        o_lk_addr = ~a;
        o_lk_data = ~d;
        repeat (tail) tick(idle);
    endtask
endmodule
`default_nettype wire
